//--- core/rail_ctrl.sv
// rail enable gating, turn-off delay, dead-time and scratch storage
// Notes on behaviour
// - 16-bit scratch word, reads back unchanged, saved to and loaded from nvm.
// - dead-time select bit 0 sets channel one dead-time.
// - dead-time select bit 1 sets channel two dead-time independently.
// - select bit one gives longer dead-time, zero gives shorter.
// - pin-only source: enable follows pin, command on/off ignored.
// - command-only source: enable follows command, pin ignored.
// - both sources: on only while pin and command both request on.
// - enable pin polarity configurable, active high or active low.
// - second feedback strapped to bias rail: two-phase, both follow channel one.
// - power good low at startup, after fault, and when rail off.
// - turn-off request waits programmable delay before switching stops.
`timescale 1ns/10ps
`include "rail_cfg.svh"
module rail_ctrl (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] rail_enable_pin,
  input wire logic second_feedback_strap,
  input wire logic [1:0] operation_on,
  input wire rail_pkg::enable_cfg_t enable_cfg,
  input wire logic [15:0] turn_off_delay_setting,
  input wire logic [1:0] rail_fault,
  input wire logic [1:0] rail_in_window,
  input wire logic scratch_wr,
  input wire logic [15:0] scratch_wdata,
  input wire logic dt_wr,
  input wire logic [7:0] dt_wdata,
  input wire logic nvm_restore,
  input wire logic [15:0] nvm_scratch_in,
  input wire logic nvm_store,
  output logic [15:0] user_scratch_word,
  output logic [7:0] dead_time_select,
  output logic [15:0] nvm_scratch_out,
  output logic nvm_write_strobe,
  output logic two_phase_mode,
  output logic [1:0] switching_enable,
  output logic [1:0] power_good_output,
  output rail_pkg::gate_pair_t [1:0] gate_drive
);
  // ****************************************************
  // input synchronisers
  // ****************************************************
  logic [2:0] pin_meta_reg;
  logic [2:0] pin_sync_reg;
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pin_meta_reg <= 3'h0;
      pin_sync_reg <= 3'h0;
    end
    else
    begin
      pin_meta_reg <= {second_feedback_strap, rail_enable_pin};
      pin_sync_reg <= pin_meta_reg;
    end
  end

  // ****************************************************
  // scratch word and nvm copy
  // ****************************************************
  logic [15:0] scratch_reg, scratch_next;
  logic [15:0] nvm_out_reg, nvm_out_next;
  logic nvm_wr_reg, nvm_wr_next;
  always_comb
  begin
    scratch_next = scratch_reg;
    nvm_out_next = nvm_out_reg;
    nvm_wr_next = 1'b0;
    // restore wins over a host write in the same cycle
    if (nvm_restore)
      scratch_next = nvm_scratch_in;
    else if (scratch_wr)
      scratch_next = scratch_wdata;
    // store copies the value held before this edge
    if (nvm_store)
    begin
      nvm_out_next = scratch_reg;
      nvm_wr_next = 1'b1;
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      scratch_reg <= `SCRATCH_RESET;
      nvm_out_reg <= 16'h0000;
      nvm_wr_reg <= 1'b0;
    end
    else
    begin
      scratch_reg <= scratch_next;
      nvm_out_reg <= nvm_out_next;
      nvm_wr_reg <= nvm_wr_next;
    end
  end
  assign user_scratch_word = scratch_reg;
  assign nvm_scratch_out = nvm_out_reg;
  assign nvm_write_strobe = nvm_wr_reg;

  // ****************************************************
  // dead-time select register
  // ****************************************************
  logic [7:0] dt_reg, dt_next;
  always_comb
  begin
    dt_next = dt_reg;
    if (dt_wr)
      dt_next = dt_wdata;
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      dt_reg <= `DT_SEL_RESET;
    else
      dt_reg <= dt_next;
  end
  assign dead_time_select = dt_reg;

  // ****************************************************
  // two-phase strap capture
  // ****************************************************
  // synchroniser is cleared by reset: wait two edges before sampling
  logic [1:0] strap_cnt_reg, strap_cnt_next;
  logic two_phase_reg, two_phase_next;
  always_comb
  begin
    strap_cnt_next = strap_cnt_reg;
    two_phase_next = two_phase_reg;
    if (strap_cnt_reg != 2'h3)
      strap_cnt_next = strap_cnt_reg + 2'h1;
    // strap read once, from the second flip-flop
    if (strap_cnt_reg == 2'h2)
      two_phase_next = pin_sync_reg[2];
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strap_cnt_reg <= 2'h0;
      two_phase_reg <= 1'b0;
    end
    else
    begin
      strap_cnt_reg <= strap_cnt_next;
      two_phase_reg <= two_phase_next;
    end
  end
  assign two_phase_mode = two_phase_reg;

  // ****************************************************
  // enable gating and turn-off delay per rail
  // ****************************************************
  rail_pkg::rail_state_t state_reg [2];
  rail_pkg::rail_state_t state_next [2];
  logic [15:0] delay_reg [2];
  logic [15:0] delay_next [2];
  logic [1:0] request;
  logic [1:0] pin_on;
  logic [1:0] op_on;
  logic [1:0] sw_en_reg, sw_en_next;
  logic [1:0] pg_reg, pg_next;
  always_comb
  begin
    sw_en_next = sw_en_reg;
    pg_next = pg_reg;
    for (int i = 0; i < 2; i++)
    begin
      // channel two follows channel one in two-phase mode
      pin_on[i] = (two_phase_reg ? pin_sync_reg[0] : pin_sync_reg[i])
                  ^ enable_cfg.pin_active_low;
      op_on[i] = two_phase_reg ? operation_on[0] : operation_on[i];
      case (enable_cfg.source)
        `SRC_PIN: request[i] = pin_on[i];
        `SRC_CMD: request[i] = op_on[i];
        `SRC_BOTH: request[i] = pin_on[i] & op_on[i];
        default: request[i] = 1'b1;
      endcase
      state_next[i] = state_reg[i];
      delay_next[i] = delay_reg[i];
      case (state_reg[i])
        rail_pkg::ST_OFF:
          if (request[i])
            state_next[i] = rail_pkg::ST_ON;
        rail_pkg::ST_ON:
          if (!request[i])
          begin
            state_next[i] = rail_pkg::ST_DELAY;
            delay_next[i] = turn_off_delay_setting;
          end
        rail_pkg::ST_DELAY:
          if (request[i])
            state_next[i] = rail_pkg::ST_ON;
          else if (delay_reg[i] == 16'h0000)
            state_next[i] = rail_pkg::ST_OFF;
          else
            delay_next[i] = delay_reg[i] - 16'h0001;
        default:
          state_next[i] = rail_pkg::ST_OFF;
      endcase
      sw_en_next[i] = (state_next[i] != rail_pkg::ST_OFF);
      // low unless on, fault-free and output in window
      pg_next[i] = (state_next[i] == rail_pkg::ST_ON) & !rail_fault[i]
                   & rail_in_window[i];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 2; i++)
      begin
        state_reg[i] <= rail_pkg::ST_OFF;
        delay_reg[i] <= 16'h0000;
      end
      sw_en_reg <= 2'h0;
      pg_reg <= 2'h0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
      begin
        state_reg[i] <= state_next[i];
        delay_reg[i] <= delay_next[i];
      end
      sw_en_reg <= sw_en_next;
      pg_reg <= pg_next;
    end
  end
  assign switching_enable = sw_en_reg;
  assign power_good_output = pg_reg;

  // ****************************************************
  // dead-time choice latched at period start
  // ****************************************************
  logic [7:0] phase_reg [2];
  logic [7:0] phase_next [2];
  logic [1:0] long_dt_reg, long_dt_next;
  always_comb
  begin
    long_dt_next = long_dt_reg;
    // load only on wrap, never partway through a gate transition
    if (phase_reg[0] == 8'(`PERIOD_CYC - 1))
      long_dt_next[0] = dt_reg[`DT_CH1_BIT];
    if (phase_reg[1] == 8'(`PERIOD_CYC - 1))
      long_dt_next[1] = dt_reg[`DT_CH2_BIT];
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
      long_dt_reg <= 2'h0;
    else
      long_dt_reg <= long_dt_next;
  end

  // ****************************************************
  // gate drive with dead-time per channel
  // ****************************************************
  rail_pkg::gate_pair_t [1:0] gate_reg, gate_next;
  logic [7:0] dt_cyc [2];
  logic [7:0] high_end [2];
  always_comb
  begin
    for (int i = 0; i < 2; i++)
    begin
      phase_next[i] = (phase_reg[i] == 8'(`PERIOD_CYC - 1)) ? 8'h00
                      : phase_reg[i] + 8'h01;
      // second phase runs half a period apart
      if (i == 1 && two_phase_reg)
        phase_next[i] = (phase_next[0] >= 8'(`PERIOD_CYC / 2))
                        ? phase_next[0] - 8'(`PERIOD_CYC / 2)
                        : phase_next[0] + 8'(`PERIOD_CYC / 2);
      dt_cyc[i] = long_dt_reg[i] ? 8'(`DT_LONG_CYC)
                  : 8'(`DT_SHORT_CYC);
      high_end[i] = 8'(`PERIOD_CYC / 2);
      // gap, high side, gap, low side, gap before wrap
      gate_next[i].high_drive = sw_en_next[i] && phase_next[i] >= dt_cyc[i]
                                && phase_next[i] < high_end[i];
      gate_next[i].low_drive = sw_en_next[i]
                               && phase_next[i] >= high_end[i] + dt_cyc[i]
                               && phase_next[i] < 8'(`PERIOD_CYC) - dt_cyc[i];
    end
  end
  always_ff @(posedge sys_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      for (int i = 0; i < 2; i++)
        phase_reg[i] <= 8'h00;
      gate_reg <= '0;
    end
    else
    begin
      for (int i = 0; i < 2; i++)
        phase_reg[i] <= phase_next[i];
      gate_reg <= gate_next;
    end
  end
  assign gate_drive = gate_reg;
endmodule

//--- common/rail_cfg.svh
// constants for the rail enable and dead-time block
`ifndef RAIL_CFG_SVH
`define RAIL_CFG_SVH
`define SCRATCH_RESET 16'h0000
`define DT_SEL_RESET 8'h00
`define DT_CH1_BIT 0
`define DT_CH2_BIT 1
`define SRC_PIN 2'h1
`define SRC_CMD 2'h2
`define SRC_BOTH 2'h3
`define DT_SHORT_NS 20
`define DT_LONG_NS 40
`define CLK_NS 8
`define DT_SHORT_CYC ((`DT_SHORT_NS + `CLK_NS - 1) / `CLK_NS)
`define DT_LONG_CYC ((`DT_LONG_NS + `CLK_NS - 1) / `CLK_NS)
`define PERIOD_CYC 250
`endif

//--- common/rail_pkg.sv
// types for the rail enable and dead-time block
package rail_pkg;
  typedef enum logic [1:0] {
    ST_OFF = 2'b00,
    ST_ON = 2'b01,
    ST_DELAY = 2'b11
  } rail_state_t;
  typedef struct packed {
    logic high_drive;
    logic low_drive;
  } gate_pair_t;
  typedef struct packed {
    logic [1:0] source;
    logic pin_active_low;
  } enable_cfg_t;
endpackage

//--- tb/rail_ctrl_checker.sv
// port assertions for the rail enable block
`timescale 1ns/10ps
`include "rail_cfg.svh"
module rail_ctrl_checker (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic [1:0] operation_on,
  input wire rail_pkg::enable_cfg_t enable_cfg,
  input wire logic [1:0] rail_fault,
  input wire logic scratch_wr,
  input wire logic [15:0] scratch_wdata,
  input wire logic dt_wr,
  input wire logic [7:0] dt_wdata,
  input wire logic nvm_restore,
  input wire logic [15:0] nvm_scratch_in,
  input wire logic nvm_store,
  input wire logic [15:0] user_scratch_word,
  input wire logic [7:0] dead_time_select,
  input wire logic [15:0] nvm_scratch_out,
  input wire logic nvm_write_strobe,
  input wire logic two_phase_mode,
  input wire logic [1:0] switching_enable,
  input wire logic [1:0] power_good_output,
  input wire rail_pkg::gate_pair_t [1:0] gate_drive
);
  default clocking dc @(posedge sys_clk);
  endclocking
  default disable iff (!reset_n);
  scratch_wr_a: assert property (scratch_wr && !nvm_restore
    |=> user_scratch_word == $past(scratch_wdata)) else $error("scratch");
  restore_a: assert property (nvm_restore
    |=> user_scratch_word == $past(nvm_scratch_in)) else $error("restore");
  store_a: assert property (nvm_store |=> nvm_write_strobe
    && nvm_scratch_out == $past(user_scratch_word)) else $error("store");
  dt_write_a: assert property (dt_wr
    |=> dead_time_select == $past(dt_wdata)) else $error("dt");
  cmd_on_a: assert property ($rose(operation_on[0])
    && enable_cfg.source == `SRC_CMD |=> switching_enable[0])
    else $error("cmd on");
  fault_pg_a: assert property (rail_fault[0]
    |=> !power_good_output[0]) else $error("pg fault");
  off_pg_a: assert property ($fell(switching_enable[0])
    |-> !power_good_output[0]) else $error("pg off");
  two_phase_a: assert property (two_phase_mode
    && $past(two_phase_mode)
    |-> switching_enable[1] == switching_enable[0]) else $error("phase");
  no_overlap_a: assert property (!(gate_drive[0].high_drive
    && gate_drive[0].low_drive)) else $error("gate overlap");
  cover property (nvm_write_strobe);
  cover property ($fell(switching_enable[0]));
  cover property (two_phase_mode && switching_enable[0]);
endmodule
bind rail_ctrl rail_ctrl_checker u_rail_ctrl_checker (.*);

//--- tb/rail_host_model.sv
// enable pins and bus on/off command source
`timescale 1ns/10ps
module rail_host_model (
  input wire logic sys_clk,
  input wire logic active_low,
  input wire logic [1:0] pin_req,
  input wire logic [1:0] cmd_req,
  output logic [1:0] rail_enable_pin = 2'h0,
  output logic [1:0] operation_on = 2'h0
);
  // unrequested rail held at its off level
  always @(posedge sys_clk)
  begin
    rail_enable_pin <= pin_req ^ {2{active_low}};
    operation_on <= cmd_req;
  end
endmodule

//--- tb/tb_top.sv
// self-checking bench for the rail enable block
`timescale 1ns/10ps
`include "rail_cfg.svh"
module tb_top;
  logic sys_clk = 0, reset_n = 0, second_feedback_strap = 0;
  logic scratch_wr = 0, dt_wr = 0, nvm_restore = 0, nvm_store = 0;
  logic [1:0] pin_req = 0, cmd_req = 0, rail_fault = 0;
  logic [1:0] rail_in_window = 2'h3;
  logic [15:0] scratch_wdata = 0, nvm_scratch_in = 0;
  logic [15:0] turn_off_delay_setting = 16'h0004;
  logic [7:0] dt_wdata = 0;
  rail_pkg::enable_cfg_t enable_cfg = 3'h4;
  wire active_low = enable_cfg.pin_active_low;
  logic [1:0] rail_enable_pin, operation_on;
  logic [1:0] switching_enable, power_good_output;
  logic [15:0] user_scratch_word, nvm_scratch_out;
  logic [7:0] dead_time_select;
  logic nvm_write_strobe, two_phase_mode;
  rail_pkg::gate_pair_t [1:0] gate_drive;
  int errors = 0, total_checks = 0;
  rail_ctrl u_rail_ctrl (.*);
  rail_host_model u_rail_host_model (.*);
  always #4 sys_clk = ~sys_clk;
  task automatic complete_run;
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(string n, logic [15:0] e, logic [15:0] s);
    total_checks++;
    if (s !== e)
    begin
      $display("mismatch %s exp %h seen %h", n, e, s);
      errors++;
    end
  endtask
  // n rising edges, then settle on the falling edge
  task automatic nx(int n);
    repeat (n) @(posedge sys_clk);
    @(negedge sys_clk);
  endtask
  task automatic wait_se(logic v);
    int i;
    for (i = 0; i < 40 && switching_enable[0] !== v; i++)
      nx(1);
    chk("enable", v, switching_enable[0]);
    if (i == 40)
      complete_run();
  endtask
  task automatic t_regs;
    @(posedge sys_clk);
    scratch_wr <= 1;
    scratch_wdata <= 16'ha5c3;
    @(posedge sys_clk);
    scratch_wr <= 0;
    nvm_store <= 1;
    @(posedge sys_clk);
    nvm_store <= 0;
    nvm_restore <= 1;
    nvm_scratch_in <= 16'h3c5a;
    scratch_wr <= 1;
    nx(0);
    chk("nvm_out", 16'ha5c3, nvm_scratch_out);
    chk("nvm_strobe", 1, nvm_write_strobe);
    @(posedge sys_clk);
    nvm_restore <= 0;
    scratch_wr <= 0;
    dt_wr <= 1;
    dt_wdata <= 8'h02;
    @(posedge sys_clk);
    dt_wdata <= 8'h01;
    @(posedge sys_clk);
    dt_wr <= 0;
    nx(0);
    chk("scratch", 16'h3c5a, user_scratch_word);
    chk("dt", 16'h0001, dead_time_select);
  endtask
  task automatic t_cmd;
    @(posedge sys_clk);
    cmd_req <= 1;
    wait_se(1);
    chk("pg_on", 1, power_good_output[0]);
    @(posedge sys_clk);
    rail_fault <= 1;
    @(posedge sys_clk);
    rail_fault <= 0;
    cmd_req <= 0;
    nx(3);
    chk("hold", 1, switching_enable[0]);
    chk("pg_off", 0, power_good_output[0]);
    wait_se(0);
  endtask
  // cycles from low side off to high side on, rail one
  task automatic t_gap(logic [15:0] e);
    int i;
    int s;
    i = 0;
    while (i < 300 && gate_drive[0].low_drive !== 1'b1)
    begin
      nx(1);
      i++;
    end
    while (i < 600 && gate_drive[0].low_drive !== 1'b0)
    begin
      nx(1);
      i++;
    end
    s = i;
    while (i < 900 && gate_drive[0].high_drive !== 1'b1)
    begin
      nx(1);
      i++;
    end
    chk("dead_gap", e, 16'(i - s));
    if (i >= 900)
      complete_run();
  endtask
  task automatic t_pin;
    @(posedge sys_clk);
    enable_cfg <= {`SRC_PIN, 1'b1};
    pin_req <= 1;
    wait_se(1);
    @(posedge sys_clk);
    enable_cfg <= {`SRC_BOTH, 1'b0};
    nx(12);
    chk("both", 0, switching_enable[0]);
    @(posedge sys_clk);
    cmd_req <= 1;
    wait_se(1);
    @(posedge sys_clk);
    pin_req <= 0;
    wait_se(0);
  endtask
  task automatic t_two;
    @(posedge sys_clk);
    second_feedback_strap <= 1;
    enable_cfg <= {`SRC_CMD, 1'b0};
    reset_n <= 0;
    nx(2);
    @(posedge sys_clk);
    reset_n <= 1;
    nx(3);
    chk("two_phase", 1, two_phase_mode);
    wait_se(1);
    t_gap(16'(2 * `DT_SHORT_CYC));
    @(posedge sys_clk);
    dt_wr <= 1;
    dt_wdata <= 8'h01;
    @(posedge sys_clk);
    dt_wr <= 0;
    nx(260);
    t_gap(16'(2 * `DT_LONG_CYC));
    chk("rail_two", 1, switching_enable[1]);
  endtask
  initial
  begin
    nx(1);
    @(posedge sys_clk);
    reset_n <= 1;
    t_regs();
    t_cmd();
    t_pin();
    t_two();
    complete_run();
  end
endmodule
